// ---- core/sdfs_fifo_status.sv ----
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module sdfs_fifo_status (
  input wire logic clk,
  input wire logic sys_rst,
  input sdfs_pkg::sdfs_bus_t bus,
  output logic [31:0] rdata,
  input sdfs_pkg::sdfs_events_t events,
  input wire logic [1:0] transfer_direction,
  input wire logic dma_service_enable,
  input wire logic final_transfer,
  input wire logic push_valid,
  input wire logic [7:0] push_data,
  input wire logic push_last,
  output logic push_ready,
  output logic pop_valid,
  output logic [7:0] pop_data,
  input wire logic pop_ready,
  output logic dma_req,
  output logic irq
);

  //====================================================================
  // State
  logic [7:0] mem_q [0:63];
  logic [5:0] wptr_q;
  logic [5:0] rptr_q;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic flush_q;
  logic [1:0] fail_q;
  logic [1:0] fail_d;
  logic rx_last_q;
  logic [31:0] mask_q;
  logic [31:0] rdata_q;

  //====================================================================
  // Bus decode
  wire sel_status = bus.addr == sdfs_pkg::FIFO_STATUS_ADDR;
  wire sel_mask = bus.addr == sdfs_pkg::IRQ_MASK_ADDR;
  wire wr_status = bus.wr && sel_status;
  wire wr_mask = bus.wr && sel_mask;
  wire flush_wr = wr_status && bus.wdata[sdfs_pkg::FLUSH_BIT];
  wire fail_clr = wr_status
    && (bus.wdata[sdfs_pkg::FAIL_LSB +: 2] != 2'h0);
  wire last_clr = wr_status && bus.wdata[sdfs_pkg::RX_LAST_BIT];

  //====================================================================
  // FIFO handshake
  wire empty = cnt_q == 7'h00;
  wire full = cnt_q == sdfs_pkg::FIFO_BYTES;
  wire dir_tx = transfer_direction == sdfs_pkg::DIR_TX; // [RQ23]
  wire dir_rx = transfer_direction == sdfs_pkg::DIR_RX; // [RQ23]

  assign push_ready = !full && !flush_wr;
  assign pop_valid = !empty && !flush_wr;
  assign pop_data = mem_q[rptr_q];

  wire push_ok = push_valid && push_ready;
  wire pop_ok = pop_ready && pop_valid;
  // A push into a full FIFO is dropped; a pop from an empty one is void
  wire overrun = push_valid && full && !flush_wr;
  wire underrun = pop_ready && empty && !flush_wr;
  wire fail_evt = overrun || underrun;

  //====================================================================
  // Level flags, each qualified by the active direction
  wire tx_space_available = dir_tx && (cnt_q < sdfs_pkg::FIFO_BYTES);
  wire rx_data_available = dir_rx && !empty;
  wire tx_half_level = dir_tx && (cnt_q <= sdfs_pkg::HALF_LEVEL);
  wire tx_empty = dir_tx && empty;
  wire rx_full = dir_rx && full;
  wire rx_half_level = dir_rx && (cnt_q >= sdfs_pkg::HALF_LEVEL);

  // DMA service follows the flag of the current direction
  assign dma_req = dma_service_enable
    && (tx_space_available || rx_data_available); // [RQ5] [RQ24]

  //====================================================================
  // Count and failure next state
  always_comb begin
    cnt_d = cnt_q;
    if (flush_wr) begin
      cnt_d = 7'h00; // [RQ1]
    end else if (push_ok && !pop_ok) begin
      cnt_d = 7'(cnt_q + 7'h01); // [RQ12]
    end else if (pop_ok && !push_ok) begin
      cnt_d = 7'(cnt_q - 7'h01); // [RQ12]
    end
  end

  // A new failure wins over a clear written in the same cycle
  always_comb begin
    fail_d = fail_q;
    if (fail_clr) begin
      fail_d = sdfs_pkg::FAIL_NONE; // [RQ3]
    end
    if (fail_evt) begin
      fail_d = final_transfer ? sdfs_pkg::FAIL_LAST
                              : sdfs_pkg::FAIL_RUN; // [RQ2]
    end
  end

  //====================================================================
  // Storage
  always_ff @(posedge clk) begin
    if (push_ok) begin
      mem_q[wptr_q] <= push_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_q <= 6'h00;
      rptr_q <= 6'h00;
      cnt_q <= 7'h00;
    end else begin
      cnt_q <= cnt_d;
      if (flush_wr) begin
        wptr_q <= 6'h00; // [RQ1]
        rptr_q <= 6'h00;
      end else begin
        if (push_ok) begin
          wptr_q <= 6'(wptr_q + 6'h01);
        end
        if (pop_ok) begin
          rptr_q <= 6'(rptr_q + 6'h01);
        end
      end
    end
  end

  //====================================================================
  // Status flags
  wire last_set = push_ok && push_last && dir_rx;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flush_q <= 1'b0;
      fail_q <= sdfs_pkg::FAIL_NONE;
      rx_last_q <= 1'b0;
    end else begin
      // Reads back as one for a single cycle after the flush
      flush_q <= flush_wr; // [RQ1]
      fail_q <= fail_d; // [RQ2] [RQ3]
      rx_last_q <= last_set || (rx_last_q && !last_clr); // [RQ9]
    end
  end

  //====================================================================
  // Interrupt mask and gating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask_q <= sdfs_pkg::IRQ_MASK_RESET; // [RQ21]
    end else if (wr_mask) begin
      mask_q <= bus.wdata & sdfs_pkg::IRQ_MASK_RW;
    end
  end

  // Flag vector lines up bit for bit with interrupt_enable_mask
  logic [31:0] irq_flags;
  always_comb begin
    irq_flags = 32'h0000_0000;
    irq_flags[18] = events.no_busy; // [RQ14]
    irq_flags[17] = events.rsp_crc; // [RQ15]
    irq_flags[16] = events.cmd_sent; // [RQ16]
    irq_flags[15] = events.cmd_tout; // [RQ16]
    irq_flags[14] = events.rsp_end; // [RQ15]
    irq_flags[13] = events.read_wait; // [RQ17]
    irq_flags[12] = events.card_irq; // [RQ17]
    irq_flags[11] = fail_q != sdfs_pkg::FAIL_NONE; // [RQ18]
    irq_flags[10] = events.crc_sta; // [RQ19]
    irq_flags[9] = events.dat_crc; // [RQ19]
    irq_flags[8] = events.dat_tout; // [RQ20]
    irq_flags[7] = events.dat_fin; // [RQ20]
    irq_flags[6] = events.busy_fin;
    irq_flags[4] = tx_half_level;
    irq_flags[3] = tx_empty;
    irq_flags[2] = rx_last_q;
    irq_flags[1] = rx_full;
    irq_flags[0] = rx_half_level;
  end

  wire irq_any = |(irq_flags & mask_q);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_any; // [RQ22]
    end
  end

  //====================================================================
  // Register read
  logic [31:0] status_word;
  always_comb begin
    status_word = sdfs_pkg::FIFO_STATUS_RESET;
    status_word[sdfs_pkg::FLUSH_BIT] = flush_q;
    status_word[sdfs_pkg::FAIL_LSB +: 2] = fail_q;
    status_word[sdfs_pkg::TX_AVAIL_BIT] = tx_space_available; // [RQ4]
    status_word[sdfs_pkg::RX_AVAIL_BIT] = rx_data_available; // [RQ6]
    status_word[sdfs_pkg::TX_HALF_BIT] = tx_half_level; // [RQ7]
    status_word[sdfs_pkg::TX_EMPTY_BIT] = tx_empty; // [RQ8]
    status_word[sdfs_pkg::RX_LAST_BIT] = rx_last_q;
    status_word[sdfs_pkg::RX_FULL_BIT] = rx_full; // [RQ10]
    status_word[sdfs_pkg::RX_HALF_BIT] = rx_half_level; // [RQ11]
    status_word[sdfs_pkg::COUNT_W-1:0] = cnt_q; // [RQ12]
  end

  wire [31:0] rd_mux = sel_status ? status_word
                     : sel_mask ? mask_q
                     : 32'h0000_0000;

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= bus.rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign rdata = rdata_q;

  //====================================================================
  // Assertions
  sequence seq_flush_wr;
    flush_wr;
  endsequence

  sequence seq_flushed;
    (cnt_q == 7'h00 && flush_q) ##1 !flush_q;
  endsequence

  AST_FLUSH_EMPTIES: assert property ( // [RQ1]
    @(posedge clk) disable iff (sys_rst)
    seq_flush_wr ##0 !($past(flush_wr)) |=> seq_flushed
      or (seq_flush_wr ##0 1'b1)
  ) else $error("flush did not empty FIFO or self-clear");

  AST_FAIL_CODE: assert property ( // [RQ2]
    @(posedge clk) disable iff (sys_rst)
    fail_evt && !final_transfer |=> fail_q == 2'h1
  ) else $error("failure code not 01 after run error");

  AST_FAIL_HOLD: assert property ( // [RQ3]
    @(posedge clk) disable iff (sys_rst)
    fail_q != 2'h0 && !fail_clr |=> fail_q != 2'h0
  ) else $error("failure field dropped without clear");

  AST_FAIL_CLEAR: assert property ( // [RQ3]
    @(posedge clk) disable iff (sys_rst)
    fail_clr && !fail_evt |=> fail_q == 2'h0
  ) else $error("failure field not cleared by write");

  AST_TX_AVAIL_READ: assert property ( // [RQ4]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status |=> rdata[13] ==
      ($past(dir_tx) && $past(cnt_q) <= 7'h3F)
  ) else $error("tx space flag read wrong");

  AST_DMA_REQ: assert property ( // [RQ5]
    @(posedge clk) disable iff (sys_rst)
    dma_service_enable && dir_rx && cnt_q != 7'h00 |-> dma_req
  ) else $error("no DMA request with data available");

  AST_RX_AVAIL_READ: assert property ( // [RQ6]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status |=> rdata[12] ==
      ($past(dir_rx) && $past(cnt_q) >= 7'h01)
  ) else $error("rx data flag read wrong");

  AST_TX_HALF_READ: assert property ( // [RQ7]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status && dir_tx && cnt_q == 7'h21
      |=> !rdata[11]
  ) else $error("tx half flag set at 33 bytes");

  AST_TX_EMPTY: assert property ( // [RQ8]
    @(posedge clk) disable iff (sys_rst)
    dir_tx && flush_wr |=> tx_empty
  ) else $error("tx empty not set after flush");

  AST_RX_LAST: assert property ( // [RQ9]
    @(posedge clk) disable iff (sys_rst)
    last_set |=> rx_last_q
  ) else $error("rx last flag not set by final data");

  AST_RX_LAST_HOLD: assert property ( // [RQ9]
    @(posedge clk) disable iff (sys_rst)
    rx_last_q && !last_clr |=> rx_last_q
  ) else $error("rx last flag dropped without clear");

  AST_RX_LAST_CLEAR: assert property ( // [RQ9]
    @(posedge clk) disable iff (sys_rst)
    last_clr && !last_set |=> !rx_last_q
  ) else $error("rx last flag not cleared by write");

  AST_RX_FULL: assert property ( // [RQ10]
    @(posedge clk) disable iff (sys_rst)
    rx_full |-> cnt_q == 7'h40 && !push_ready
  ) else $error("rx full without 64 bytes");

  AST_RX_HALF_READ: assert property ( // [RQ11]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status && dir_rx && cnt_q == 7'h1F
      |=> !rdata[7]
  ) else $error("rx half flag set at 31 bytes");

  AST_COUNT_UP: assert property ( // [RQ12]
    @(posedge clk) disable iff (sys_rst)
    push_ok && !pop_ok && !flush_wr |=>
      cnt_q == 7'($past(cnt_q) + 7'h01)
  ) else $error("byte count did not advance on push");

  AST_MASK_RESET: assert property ( // [RQ21]
    @(posedge clk) disable iff (sys_rst)
    $fell(sys_rst) |-> mask_q == 32'h0000_0000 && !irq
  ) else $error("mask not cleared by reset");

  AST_IRQ_GATE: assert property ( // [RQ22] [RQ18]
    @(posedge clk) disable iff (sys_rst)
    mask_q[11] && fail_q != 2'h0 |=> irq
  ) else $error("enabled failure did not raise irq");

  AST_FAIL_LAST: assert property ( // [RQ2]
    @(posedge clk) disable iff (sys_rst)
    fail_evt && final_transfer |=> fail_q == 2'h2
  ) else $error("failure code not 10 in final transfer");

  AST_DMA_TX: assert property ( // [RQ5]
    @(posedge clk) disable iff (sys_rst)
    dma_service_enable && dir_tx && cnt_q != 7'h40 |-> dma_req
  ) else $error("no DMA request with space available");

  AST_DMA_OFF: assert property ( // [RQ24]
    @(posedge clk) disable iff (sys_rst)
    !dma_service_enable |-> !dma_req
  ) else $error("DMA request while polled service selected");

  AST_TX_EMPTY_READ: assert property ( // [RQ8]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status |=> rdata[10] ==
      ($past(dir_tx) && $past(cnt_q) == 7'h00)
  ) else $error("tx empty flag read wrong");

  AST_RX_FULL_READ: assert property ( // [RQ10]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status |=> rdata[8] ==
      ($past(dir_rx) && $past(cnt_q) == 7'h40)
  ) else $error("rx full flag read wrong");

  AST_COUNT_READ: assert property ( // [RQ12]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status |=> rdata[6:0] == $past(cnt_q)
  ) else $error("byte count read wrong");

  AST_COUNT_DOWN: assert property ( // [RQ12]
    @(posedge clk) disable iff (sys_rst)
    pop_ok && !push_ok && !flush_wr |=>
      cnt_q == 7'($past(cnt_q) - 7'h01)
  ) else $error("byte count did not drop on pop");

  AST_IRQ_MASKED: assert property ( // [RQ22]
    @(posedge clk) disable iff (sys_rst)
    (irq_flags & mask_q) == 32'h0000_0000 |=> !irq
  ) else $error("irq raised with no enabled flag");

  // Level flags must stay quiet in idle and busy-check phases
  AST_DIR_IDLE_READ: assert property ( // [RQ23]
    @(posedge clk) disable iff (sys_rst)
    bus.rd && sel_status && !dir_tx && !dir_rx |=>
      rdata[13:10] == 4'h0 && rdata[8:7] == 2'h0
  ) else $error("level flag read outside its direction");

endmodule : sdfs_fifo_status

// ---- core/sdfs_pkg.sv ----
//======================================================================
// Summary of operation
// (RQ1) Writing one to fifo_flush empties the FIFO; the bit self-clears.
// (RQ2) fifo_failure: 00 none, 01 failure, 10 failure in last transfer.
// (RQ3) fifo_failure holds until software writes ones to it.
// (RQ4) In transmit, tx_space_available is one at 63 bytes or fewer.
// (RQ5) With DMA enabled, the active available flag raises a DMA request.
// (RQ6) In receive, rx_data_available is one at 1 to 64 bytes.
// (RQ7) tx_half_level is one at 32 bytes or fewer.
// (RQ8) tx_empty is one exactly at zero bytes.
// (RQ9) rx_last_data sets on final block data; cleared by writing one.
// (RQ10) rx_full is one exactly at 64 bytes.
// (RQ11) rx_half_level is one at 32 to 64 bytes.
// (RQ12) fifo_byte_count reports the bytes held in the FIFO.
// (RQ13) Software clears fifo_failure and flushes after oversized last data.
// (RQ14) no_busy_irq_en gates the no-busy interrupt.
// (RQ15) Enables gate response CRC and response received interrupts.
// (RQ16) Enables gate command sent and command timeout interrupts.
// (RQ17) Enables gate read-wait and card interrupt detect interrupts.
// (RQ18) fifo_failure_irq_en gates the FIFO failure interrupt.
// (RQ19) Enables gate write CRC status and read CRC interrupts.
// (RQ20) Enables gate data timeout and transfer done interrupts.
// (RQ21) The interrupt mask resets with every enable cleared.
// (RQ22) irq is high while any enabled flag is set.
// (RQ23) transfer_direction: 00 none, 01 busy, 10 receive, 11 transmit.
// (RQ24) dma_service_enable selects polled or DMA FIFO service.
//======================================================================
package sdfs_pkg;

  //====================================================================
  // Register map
  localparam logic [31:0] FIFO_STATUS_ADDR = 32'h5A00_0038;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'h5A00_003C;
  localparam logic [31:0] FIFO_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] IRQ_MASK_RW = 32'h0007_FFDF;

  //====================================================================
  // fifo_status fields
  localparam int FLUSH_BIT = 16;
  localparam int FAIL_LSB = 14;
  localparam int TX_AVAIL_BIT = 13;
  localparam int RX_AVAIL_BIT = 12;
  localparam int TX_HALF_BIT = 11;
  localparam int TX_EMPTY_BIT = 10;
  localparam int RX_LAST_BIT = 9;
  localparam int RX_FULL_BIT = 8;
  localparam int RX_HALF_BIT = 7;
  localparam int COUNT_W = 7;

  localparam logic [1:0] FAIL_NONE = 2'h0;
  localparam logic [1:0] FAIL_RUN = 2'h1;
  localparam logic [1:0] FAIL_LAST = 2'h2;

  //====================================================================
  // FIFO geometry and levels
  localparam int PTR_W = 6;
  localparam logic [6:0] FIFO_BYTES = 7'h40;
  localparam logic [6:0] HALF_LEVEL = 7'h20;

  //====================================================================
  // transfer_direction codes
  localparam logic [1:0] DIR_NONE = 2'h0;
  localparam logic [1:0] DIR_BUSY = 2'h1;
  localparam logic [1:0] DIR_RX = 2'h2;
  localparam logic [1:0] DIR_TX = 2'h3;

  //====================================================================
  // Carriers
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sdfs_bus_t;

  // Sticky flags held by the command and data status registers
  typedef struct packed {
    logic no_busy;
    logic rsp_crc;
    logic cmd_sent;
    logic cmd_tout;
    logic rsp_end;
    logic read_wait;
    logic card_irq;
    logic crc_sta;
    logic dat_crc;
    logic dat_tout;
    logic dat_fin;
    logic busy_fin;
  } sdfs_events_t;

endpackage : sdfs_pkg

// ---- verification/sdfs_card_model.sv ----
`timescale 1ns/1ps
module sdfs_card_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fill,
  input wire logic drain,
  input wire logic rude,
  input wire logic last,
  input wire logic sync,
  output logic push_valid,
  output logic [7:0] push_data,
  output logic push_last,
  input wire logic push_ready,
  input wire logic pop_valid,
  input wire logic [7:0] pop_data,
  output logic pop_ready,
  output logic [7:0] bad
);
  logic [7:0] seq_q;
  logic [7:0] exp_q;
  //==================================================================
  // Card side of the FIFO
  // Only a rude card pushes into a full FIFO or pulls from an empty one
  assign push_valid = fill && (push_ready || rude);
  assign pop_ready = drain && (pop_valid || rude);
  assign push_data = seq_q;
  assign push_last = last;
  // A flush loses bytes, so the bench resyncs the expected order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_q <= 8'h00;
      exp_q <= 8'h00;
      bad <= 8'h00;
    end else begin
      if (push_valid && push_ready) seq_q <= seq_q + 8'h01;
      if (sync) exp_q <= seq_q;
      else if (pop_valid && pop_ready) begin
        exp_q <= exp_q + 8'h01;
        if (pop_data !== exp_q) bad <= bad + 8'h01;
      end
    end
  end
endmodule : sdfs_card_model

// ---- verification/sd_host_fifo_status_irq_mask_bench.sv ----
`timescale 1ns/1ps
module sd_host_fifo_status_irq_mask_bench;
  localparam logic [31:0] ST = sdfs_pkg::FIFO_STATUS_ADDR;
  localparam logic [31:0] MK = sdfs_pkg::IRQ_MASK_ADDR;
  logic clk, sys_rst, dma, fin, fill, drain, rude, last, sync;
  logic pv, pl, pr, qv, qr, dreq, irq;
  logic [7:0] pd, qd, bad;
  logic [1:0] dir;
  logic [31:0] rdata, m;
  logic [15:0] lf;
  logic [11:0] e;
  sdfs_pkg::sdfs_bus_t b;
  sdfs_pkg::sdfs_events_t ev;
  int n_errors, total_checks, c;
  int lv[6];

  sdfs_fifo_status sdfs_fifo_status_inst (.clk(clk), .sys_rst(sys_rst),
    .bus(b), .rdata(rdata), .events(ev), .transfer_direction(dir),
    .dma_service_enable(dma), .final_transfer(fin), .push_valid(pv),
    .push_data(pd), .push_last(pl), .push_ready(pr), .pop_valid(qv),
    .pop_data(qd), .pop_ready(qr), .dma_req(dreq), .irq(irq));
  sdfs_card_model sdfs_card_model_inst (.clk(clk), .sys_rst(sys_rst),
    .fill(fill), .drain(drain), .rude(rude), .last(last), .sync(sync),
    .push_valid(pv), .push_data(pd), .push_last(pl), .push_ready(pr),
    .pop_valid(qv), .pop_data(qd), .pop_ready(qr), .bad(bad));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  //==================================================================
  // Expectations
  function automatic logic [15:0] lnext(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lnext
  function automatic logic [31:0] exp_st(int n, logic [1:0] d,
      logic [1:0] f, logic l);
    logic [31:0] s;
    s = 32'(n);
    s[15:14] = f;
    s[9] = l;
    if (d == sdfs_pkg::DIR_TX) begin
      s[13] = n != 64;
      s[11] = n <= 32;
      s[10] = n == 0;
    end
    if (d == sdfs_pkg::DIR_RX) begin
      s[12] = n != 0;
      s[8] = n == 64;
      s[7] = n >= 32;
    end
    return s;
  endfunction : exp_st
  // Event flags land on their mask bits; bit 11 is the FIFO failure
  function automatic logic [31:0] evmap(logic [11:0] x);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[18:12] = x[11:5];
    r[10:6] = x[4:0];
    return r;
  endfunction : evmap

  //==================================================================
  // Drivers and checks
  task automatic chk(logic [31:0] g, logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  task automatic op(logic w, logic r, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    b <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask : op
  task automatic wr(logic [31:0] a, logic [31:0] d);
    op(1'b1, 1'b0, a, d);
    op(1'b0, 1'b0, 32'h0, 32'h0);
  endtask : wr
  task automatic rdchk(logic [31:0] a, logic [31:0] x);
    op(1'b0, 1'b1, a, 32'h0);
    op(1'b0, 1'b0, 32'h0, 32'h0);
    #1;
    chk(rdata, x);
  endtask : rdchk
  task automatic move(int n, logic p);
    if (n > 0) begin
      @(posedge clk);
      if (p) drain <= 1'b1;
      else fill <= 1'b1;
      repeat (n) @(posedge clk);
      if (p) drain <= 1'b0;
      else fill <= 1'b0;
    end
  endtask : move
  task automatic irqchk(logic x);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(irq), 32'(x));
  endtask : irqchk
  task automatic flush();
    wr(ST, 32'h0001_0000);
    @(posedge clk);
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
  endtask : flush
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial begin
    b = '0;
    ev = '0;
    {dir, dma, fin, fill, drain, rude, last, sync} = '0;
    n_errors = 0;
    total_checks = 0;
    lf = 16'h002C;
    lv = '{1, 31, 32, 33, 63, 64};
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(ST, 32'h0);
    rdchk(MK, 32'h0);
    rdchk(32'h5A00_0040, 32'h0);
    repeat (4) begin
      lf = lnext(lf);
      m = {lf, lnext(lf)};
      wr(MK, m);
      rdchk(MK, m & sdfs_pkg::IRQ_MASK_RW);
    end
    wr(MK, 32'h0);
    $display("test registers done");
    dir <= sdfs_pkg::DIR_RX;
    dma <= 1'b1;
    c = 0;
    foreach (lv[i]) begin
      move(lv[i] - c, 1'b0);
      c = lv[i];
      rdchk(ST, exp_st(c, dir, 2'h0, 1'b0));
      chk(32'(dreq), 32'h1);
    end
    dma <= 1'b0;
    rude <= 1'b1;
    move(1, 1'b0);
    chk(32'(dreq), 32'h0);
    rdchk(ST, exp_st(64, sdfs_pkg::DIR_RX, 2'h1, 1'b0));
    wr(MK, 32'h0000_0800);
    irqchk(1'b1);
    wr(ST, 32'h0000_4000);
    rdchk(ST, exp_st(64, sdfs_pkg::DIR_RX, 2'h0, 1'b0));
    irqchk(1'b0);
    fin <= 1'b1;
    move(1, 1'b0);
    rdchk(ST, exp_st(64, sdfs_pkg::DIR_RX, 2'h2, 1'b0));
    wr(ST, 32'h0000_8000);
    rude <= 1'b0;
    fin <= 1'b0;
    op(1'b1, 1'b0, ST, 32'h0001_0000);
    rdchk(ST, 32'h0001_0000);
    rdchk(ST, exp_st(0, sdfs_pkg::DIR_RX, 2'h0, 1'b0));
    sync <= 1'b1;
    @(posedge clk);
    sync <= 1'b0;
    $display("test receive done");
    dir <= sdfs_pkg::DIR_TX;
    dma <= 1'b1;
    lv = '{1, 32, 33, 63, 64, 64};
    rdchk(ST, exp_st(0, sdfs_pkg::DIR_TX, 2'h0, 1'b0));
    c = 0;
    foreach (lv[i]) begin
      move(lv[i] - c, 1'b0);
      c = lv[i];
      rdchk(ST, exp_st(c, sdfs_pkg::DIR_TX, 2'h0, 1'b0));
      chk(32'(dreq), 32'(c != 64));
    end
    move(64, 1'b1);
    rude <= 1'b1;
    move(1, 1'b1);
    rdchk(ST, exp_st(0, sdfs_pkg::DIR_TX, 2'h1, 1'b0));
    chk(32'(bad), 32'h0);
    rude <= 1'b0;
    wr(ST, 32'h0001_C000);
    rdchk(ST, exp_st(0, sdfs_pkg::DIR_TX, 2'h0, 1'b0));
    $display("test transmit done");
    dir <= sdfs_pkg::DIR_RX;
    last <= 1'b1;
    move(1, 1'b0);
    last <= 1'b0;
    move(1, 1'b0);
    rdchk(ST, exp_st(2, sdfs_pkg::DIR_RX, 2'h0, 1'b1));
    wr(ST, 32'h0000_0200);
    rdchk(ST, exp_st(2, sdfs_pkg::DIR_RX, 2'h0, 1'b0));
    flush();
    dir <= sdfs_pkg::DIR_NONE;
    $display("test last data done");
    for (int i = 0; i < 12; i++) begin
      m = evmap(12'(1 << i));
      @(posedge clk);
      ev <= sdfs_pkg::sdfs_events_t'(12'(1 << i));
      wr(MK, ~m);
      irqchk(1'b0);
      wr(MK, m);
      irqchk(1'b1);
    end
    repeat (16) begin
      lf = lnext(lf);
      e = lf[11:0];
      lf = lnext(lf);
      m = {lf, lf} & sdfs_pkg::IRQ_MASK_RW;
      @(posedge clk);
      ev <= sdfs_pkg::sdfs_events_t'(e);
      wr(MK, m);
      irqchk(|(evmap(e) & m));
    end
    $display("test interrupts done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdchk(MK, 32'h0);
    irqchk(1'b0);
    dir <= sdfs_pkg::DIR_BUSY;
    move(40, 1'b0);
    rdchk(ST, exp_st(40, sdfs_pkg::DIR_BUSY, 2'h0, 1'b0));
    chk(32'(dreq), 32'h0);
    $display("test reset and busy mode done");
    close_out();
  end
endmodule : sd_host_fifo_status_irq_mask_bench
